//--- core/rdm_pkg.sv
// Operation
// R1 - Eight independently switched low-side output channels
// R2 - Power-up loads defaults, idle, all off
// R3 - Reset pin low forces defaults and standby
// R4 - Fallback pin high enters fallback, clears registers
// R5 - Fallback: direct pins 1-4 drive channels 1-4
// R6 - Fallback: channels 5-8 held off
// R7 - Fallback: serial writes ignored entirely
// R8 - Fallback pin wins over reset pin
// R9 - Fallback pin wakes device from standby
// R10 - Fallback exit resets registers, standby or idle
// R11 - First transfer after fallback reports reset flag
// R12 - Four direct control pins available for channels
// R13 - Source-select field picks governing direct pin
// R14 - Open direct pin reads low, channel off
// R15 - Host drives reset pin active low
// R16 - Direct pin high means on, low off
// R17 - Reset release without fallback enters idle
package rdm_pkg;

    // ==========================================================
    // Sizes
    localparam int N_CHANNELS = 8;
    localparam int N_PINS     = 4;
    localparam int N_FALLBACK = 4;

    // ==========================================================
    // Reset values
    localparam logic [7:0]  CH_CMD_RESET  = 8'h00;
    localparam logic [7:0]  PIN_EN_RESET  = 8'h00;
    localparam logic [15:0] SRC_SEL_RESET = 16'h0000;

    // ==========================================================
    // Operating modes
    typedef enum logic [1:0] {
        RDM_IDLE,
        RDM_STANDBY,
        RDM_NORMAL,
        RDM_FALLBACK
    } rdm_mode_t;

    // Register image written over the serial interface
    typedef struct packed {
        logic [15:0] src_sel;   // Two bits per channel: direct pin index
        logic [7:0]  pin_en;    // Channel follows its direct pin
        logic [7:0]  ch_cmd;    // Register on/off command per channel
    } rdm_regs_t;

    // Synchronised pin levels
    typedef struct packed {
        logic       fallback;
        logic       reset_n;
        logic [3:0] direct;
    } rdm_pins_t;

endpackage

//--- core/rdm_pin_sync.sv
`timescale 1ns/1ps
// ==============================================================
// Two-stage synchroniser for the asynchronous control pins
module rdm_pin_sync (
    // Clock and control
    input  wire logic               core_clk,
    input  wire logic               srst,
    input  wire logic               clk_en,
    // Raw pins
    input  wire logic [5:0]         pins_raw,
    // Synchronised
    output      rdm_pkg::rdm_pins_t pins_sync
);

    logic [5:0] stage1;   // Metastable stage, read only by stage2
    logic [5:0] stage2;   // Safe stage

    // Reset to zero: open pins read low, reset pin reads asserted
    always_ff @(posedge core_clk) begin
        if (srst) begin
            stage1 <= 6'h00;
            stage2 <= 6'h00;
        end else if (clk_en) begin
            stage1 <= pins_raw;
            stage2 <= stage1;
        end
    end

    assign pins_sync = rdm_pkg::rdm_pins_t'(stage2);

endmodule

//--- core/rdm_mode_ctrl.sv
`timescale 1ns/1ps
// ==============================================================
// Mode and input-routing control for an eight-channel relay driver
module rdm_mode_ctrl (
    // Clock, enable, power-on reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic             clk_en,
    // Device pins (asynchronous)
    input  wire logic             reset_pin_n,
    input  wire logic             fallback_drive_pin,
    input  wire logic             direct_control_pin_1,
    input  wire logic             direct_control_pin_2,
    input  wire logic             direct_control_pin_3,
    input  wire logic             direct_control_pin_4,
    // Decoded serial register write (core clock)
    input  wire logic             reg_wr,
    input  wire rdm_pkg::rdm_regs_t reg_wdata,
    // Serial transfer completion (core clock)
    input  wire logic             xfer_done,
    // Channel outputs
    output      logic [7:0]       load_channel,
    // Status
    output      rdm_pkg::rdm_mode_t mode,
    output      rdm_pkg::rdm_regs_t regs,
    output      logic             reset_indication_flag
);

    // ==========================================================
    // Pin synchronisation
    rdm_pkg::rdm_pins_t pins;      // Pins after two flops
    logic               in_fb_q;   // Fallback seen last cycle

    rdm_pin_sync u_sync (
        .core_clk  (core_clk),
        .srst      (srst),
        .clk_en    (clk_en),
        .pins_raw  ({fallback_drive_pin, reset_pin_n,
                     direct_control_pin_4, direct_control_pin_3,
                     direct_control_pin_2, direct_control_pin_1}),
        .pins_sync (pins)
    );

    // Decoded conditions
    logic fb_active;      // Fallback requested
    logic rst_active;     // Reset pin asserted, no fallback
    logic fb_exit;        // Fallback just released
    logic regs_clear;     // Registers forced to defaults

    assign fb_active  = pins.fallback;                      // R8
    assign rst_active = !pins.reset_n && !pins.fallback;    // R3 R8
    assign fb_exit    = in_fb_q && !pins.fallback;
    // Entry, presence and exit of fallback all clear registers
    assign regs_clear = fb_active || fb_exit || rst_active; // R4 R10

    // ==========================================================
    // Fallback history
    always_ff @(posedge core_clk) begin
        if (srst) begin
            in_fb_q <= 1'b0;
        end else if (clk_en) begin
            in_fb_q <= pins.fallback;
        end
    end

    // ==========================================================
    // Operating mode
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mode <= rdm_pkg::RDM_IDLE;                       // R2
        end else if (clk_en) begin
            if (fb_active) begin
                // Also wakes from standby
                mode <= rdm_pkg::RDM_FALLBACK;               // R4 R9
            end else if (rst_active) begin
                mode <= rdm_pkg::RDM_STANDBY;                // R3 R10
            end else if (fb_exit || mode == rdm_pkg::RDM_STANDBY) begin
                // Leave via idle, all channels off
                mode <= rdm_pkg::RDM_IDLE;                   // R10 R17
            end else if (reg_wr) begin
                mode <= rdm_pkg::RDM_NORMAL;
            end
        end
    end

    // ==========================================================
    // Register image; writes dropped while cleared
    always_ff @(posedge core_clk) begin
        if (srst) begin
            regs.ch_cmd  <= rdm_pkg::CH_CMD_RESET;           // R2
            regs.pin_en  <= rdm_pkg::PIN_EN_RESET;
            regs.src_sel <= rdm_pkg::SRC_SEL_RESET;
        end else if (clk_en) begin
            if (regs_clear) begin
                // Serial writes have no effect here
                regs.ch_cmd  <= rdm_pkg::CH_CMD_RESET;       // R7 R3 R4
                regs.pin_en  <= rdm_pkg::PIN_EN_RESET;
                regs.src_sel <= rdm_pkg::SRC_SEL_RESET;
            end else if (reg_wr && !fb_exit) begin
                regs <= reg_wdata;                           // R13
            end
        end
    end

    // ==========================================================
    // Reset indication for the next transfer after fallback
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reset_indication_flag <= 1'b0;
        end else if (clk_en) begin
            if (fb_exit) begin
                // Set wins over a coincident clear
                reset_indication_flag <= 1'b1;               // R11
            end else if (xfer_done && !fb_active) begin
                reset_indication_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Channel drive: one flop per channel
    genvar ch;
    generate
        for (ch = 0; ch < rdm_pkg::N_CHANNELS; ch++) begin : g_ch
            logic [1:0] sel;   // Selected direct pin
            logic       pin;   // Its level; open pin reads low
            logic       next_on;

            assign sel = regs.src_sel[2*ch +: 2];
            assign pin = pins.direct[sel];                   // R12 R13 R14

            always_comb begin
                next_on = 1'b0;
                if (mode == rdm_pkg::RDM_FALLBACK) begin
                    if (ch < rdm_pkg::N_FALLBACK) begin
                        next_on = pins.direct[ch];           // R5
                    end else begin
                        next_on = 1'b0;                      // R6
                    end
                end else if (mode == rdm_pkg::RDM_NORMAL) begin
                    if (regs.pin_en[ch]) begin
                        next_on = pin;                       // R16
                    end else begin
                        next_on = regs.ch_cmd[ch];           // R1
                    end
                end
            end

            always_ff @(posedge core_clk) begin
                if (srst) begin
                    load_channel[ch] <= 1'b0;
                end else if (clk_en) begin
                    load_channel[ch] <= next_on;
                end
            end
        end
    endgenerate

endmodule

//--- test/rdm_host_model.sv
`timescale 1ns/1ps
// ==========
// Host side: controller pins and decoded serial writes
module rdm_host_model (
    // Clock
    input  wire logic               core_clk,
    // Pins
    output logic                    reset_pin_n,
    output logic                    fallback_drive_pin,
    output logic [3:0]              direct,
    // Serial side
    output logic                    reg_wr,
    output rdm_pkg::rdm_regs_t      reg_wdata,
    output logic                    xfer_done
);
    // Idle: reset pin released, no traffic
    initial begin
        reset_pin_n = 1'b1;
        fallback_drive_pin = 1'b0;
        direct = 4'h0;
        reg_wr = 1'b0;
        reg_wdata = '0;
        xfer_done = 1'b0;
    end
    // Pin levels change off the sampling edge
    task automatic pins(input logic rn, input logic fb, input logic [3:0] d);
        @(negedge core_clk);
        reset_pin_n = rn;
        fallback_drive_pin = fb;
        direct = d;
    endtask
    // One-cycle write pulse; data goes stale after so nothing leans on it
    task automatic wr(input logic [31:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // Transfer completion pulse
    task automatic xfer();
        @(negedge core_clk);
        xfer_done = 1'b1;
        @(negedge core_clk);
        xfer_done = 1'b0;
    endtask
endmodule

//--- test/rdm_checker.sv
`timescale 1ns/1ps
// ==========
// Port-level checks on mode control
module rdm_checker (
    input wire logic core_clk, srst, clk_en, reset_pin_n, fallback_drive_pin,
    input wire logic direct_control_pin_1, direct_control_pin_2,
    input wire logic direct_control_pin_3, direct_control_pin_4,
    input wire logic reg_wr, xfer_done, reset_indication_flag,
    input wire rdm_pkg::rdm_regs_t reg_wdata, regs,
    input wire logic [7:0] load_channel,
    input wire rdm_pkg::rdm_mode_t mode
);
    default clocking @(posedge core_clk); endclocking
    // A frozen core holds its state, so timed checks in flight are abandoned and start afresh after it
    default disable iff (srst || !clk_en);
    // Pin bundle, 6 cycles covers synchroniser latency
    wire [3:0] dp = {direct_control_pin_4, direct_control_pin_3,
                     direct_control_pin_2, direct_control_pin_1};
    wire fb = (mode == rdm_pkg::RDM_FALLBACK);
    sequence stable_fb; (fallback_drive_pin && $stable(dp))[*6]; endsequence
    fb_enter_a: assert property (fallback_drive_pin[*6] |-> fb)
        else $error("fallback not entered");
    fb_route_a: assert property (stable_fb |-> load_channel == {4'h0, dp})
        else $error("fallback routing wrong");
    fb_clear_a: assert property ($rose(fb) |-> regs == '0)
        else $error("regs not cleared on fallback");
    fb_nowr_a: assert property (fb && reg_wr |=> regs == '0)
        else $error("write taken in fallback");
    fb_exit_a: assert property ($fell(fb) |-> reset_indication_flag && regs == '0)
        else $error("exit flag or clear missing");
    stby_a: assert property ((!reset_pin_n && !fallback_drive_pin)[*6] |->
        mode == rdm_pkg::RDM_STANDBY && load_channel == 8'h00)
        else $error("standby not held");
    flag_clr_a: assert property (xfer_done && !fb |=> !reset_indication_flag)
        else $error("flag not cleared");
    wr_take_a: assert property ((reset_pin_n && !fallback_drive_pin)[*5] ##0 reg_wr &&
        mode inside {rdm_pkg::RDM_IDLE, rdm_pkg::RDM_NORMAL} |=>
        regs == $past(reg_wdata) && mode == rdm_pkg::RDM_NORMAL)
        else $error("write not applied");
    idle_off_a: assert property ((!fb && mode == rdm_pkg::RDM_IDLE) [*2] |->
        load_channel == 8'h00)
        else $error("idle channel on");
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
// ==========
// Bench top
module tb;
    logic core_clk = 1'b0, srst = 1'b1;
    logic rn, fb, wr, xd;
    logic [3:0] d;
    rdm_pkg::rdm_regs_t wd, regs;
    rdm_pkg::rdm_mode_t mode;
    logic [7:0] load;
    logic flag;
    logic ce = 1'b1;
    int err_count = 0, n_checks = 0;
    always #2.5 core_clk = ~core_clk;
    rdm_host_model rdm_host_model_i (.core_clk, .reset_pin_n(rn), .fallback_drive_pin(fb),
        .direct(d), .reg_wr(wr), .reg_wdata(wd), .xfer_done(xd));
    // Clock enable driven by the bench so the freeze path is exercised
    rdm_mode_ctrl rdm_mode_ctrl_i (.core_clk, .srst, .clk_en(ce), .reset_pin_n(rn),
        .fallback_drive_pin(fb), .direct_control_pin_1(d[0]), .direct_control_pin_2(d[1]),
        .direct_control_pin_3(d[2]), .direct_control_pin_4(d[3]), .reg_wr(wr),
        .reg_wdata(wd), .xfer_done(xd), .load_channel(load), .mode(mode), .regs(regs),
        .reset_indication_flag(flag));
    // Compare seen against expected
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Settle past the synchroniser and output stage
    task automatic st(input logic [1:0] m, input logic [7:0] l, input logic [31:0] r);
        repeat (6) @(negedge core_clk);
        chk("mode", mode, m);
        chk("load", load, l);
        chk("regs", regs, r);
    endtask
    // Hang guard
    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(negedge core_clk);
        srst = 1'b0;
        st(rdm_pkg::RDM_IDLE, 8'h00, 0);
        // Upper four follow pins 1..4, lower four on by command
        rdm_host_model_i.pins(1'b1, 1'b0, 4'h5);
        rdm_host_model_i.wr(32'hE4E4_F00F);
        st(rdm_pkg::RDM_NORMAL, 8'h5F, 32'hE4E4_F00F);
        // Frozen core ignores a write and holds every output
        ce = 1'b0;
        rdm_host_model_i.wr(32'h0000_0000);
        st(rdm_pkg::RDM_NORMAL, 8'h5F, 32'hE4E4_F00F);
        ce = 1'b1;
        rdm_host_model_i.pins(1'b1, 1'b0, 4'h0);
        st(rdm_pkg::RDM_NORMAL, 8'h0F, 32'hE4E4_F00F);
        rdm_host_model_i.pins(1'b1, 1'b1, 4'hA);
        st(rdm_pkg::RDM_FALLBACK, 8'h0A, 0);
        rdm_host_model_i.wr(32'hFFFF_FFFF);
        rdm_host_model_i.pins(1'b0, 1'b1, 4'hA);
        st(rdm_pkg::RDM_FALLBACK, 8'h0A, 0);
        rdm_host_model_i.pins(1'b0, 1'b0, 4'hA);
        st(rdm_pkg::RDM_STANDBY, 8'h00, 0);
        chk("flag", flag, 1);
        rdm_host_model_i.pins(1'b0, 1'b1, 4'h3);
        st(rdm_pkg::RDM_FALLBACK, 8'h03, 0);
        rdm_host_model_i.pins(1'b1, 1'b0, 4'h3);
        st(rdm_pkg::RDM_IDLE, 8'h00, 0);
        rdm_host_model_i.xfer();
        @(negedge core_clk);
        chk("flag", flag, 0);
        report_and_stop();
    end
endmodule
bind rdm_mode_ctrl rdm_checker rdm_checker_i (.core_clk, .srst, .clk_en, .reset_pin_n,
    .fallback_drive_pin, .direct_control_pin_1, .direct_control_pin_2,
    .direct_control_pin_3, .direct_control_pin_4, .reg_wr, .xfer_done,
    .reset_indication_flag, .reg_wdata, .regs, .load_channel, .mode);
